// >>> rtl/cpck_map.svh
// constants for the coprocessor control parity checker
`ifndef CPCK_MAP_SVH
`define CPCK_MAP_SVH

`define CPCK_CTRL_W 8
`define CPCK_CTRL_RST 1'h0
`define CPCK_PAR_RST 1'h1
`define CPCK_FLAG_RST 1'h0
`define CPCK_SRC_N 3

`endif

// >>> rtl/cpck_parity_gen.sv
// odd parity generator over a control group
module cpck_parity_gen #(
	parameter int W = 8
) (
	input wire logic [W-1:0] data,
	output logic parity
);

	// odd: data plus parity always holds an odd number of ones
	assign parity = ~(^data);

endmodule

// >>> rtl/cpck_pkg.sv
// types shared by the coprocessor control parity checker
package cpck_pkg;

	typedef enum int unsigned {
		CPCK_SRC_EXT,
		CPCK_SRC_INT_RX,
		CPCK_SRC_INT_TX
	} cpck_src_e;

	typedef logic [2:0] cpck_cause_t;

endpackage

// >>> rtl/cpck_top.sv
// parity protection of the control group between the integer and float units
`include "cpck_map.svh"

module cpck_top #(
	parameter int CTRL_W = `CPCK_CTRL_W
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic integer_unit_legacy_strap_n,
	input wire logic float_unit_legacy_strap_n,
	input wire logic [CTRL_W-1:0] ctrl_tx,
	output logic [CTRL_W-1:0] ctrl_to_float,
	output logic integer_to_float_parity,
	input wire logic [CTRL_W-1:0] ctrl_from_float,
	input wire logic float_to_integer_parity,
	output logic [CTRL_W-1:0] ctrl_rx,
	output logic check_active,
	output logic hardware_error_flag,
	output cpck_pkg::cpck_cause_t error_cause,
	output logic error_sticky,
	input wire logic error_clear
);

	logic [CTRL_W-1:0] tx_ctrl_reg;
	logic tx_par_reg;
	logic [CTRL_W-1:0] rx_ctrl_reg;
	logic rx_ipar_reg;
	logic check_active_reg;
	logic flag_reg;
	cpck_pkg::cpck_cause_t cause_reg;
	cpck_pkg::cpck_cause_t cause_next;
	logic sticky_reg;
	logic tx_par_next;
	logic rx_ipar_next;
	logic tx_par_recalc;
	logic rx_par_recalc;
	logic check_en;
	logic ext_mismatch;
	logic int_rx_mismatch;
	logic int_tx_mismatch;
	logic any_err;

	// true when a group and its parity bit hold an odd count of ones
	function automatic logic odd_ok(input logic [CTRL_W-1:0] d, input logic p);
		odd_ok = ^{d, p};
	endfunction

	// straps are active low: low means legacy mode, checking off
	assign check_en = integer_unit_legacy_strap_n & float_unit_legacy_strap_n;

	cpck_parity_gen #(
		.W(CTRL_W)
	) u_tx_gen (
		.data(ctrl_tx),
		.parity(tx_par_next)
	);

	// internal parity travels with the received group through the holding stage
	cpck_parity_gen #(
		.W(CTRL_W)
	) u_rx_gen (
		.data(ctrl_from_float),
		.parity(rx_ipar_next)
	);

	cpck_parity_gen #(
		.W(CTRL_W)
	) u_tx_chk (
		.data(tx_ctrl_reg),
		.parity(tx_par_recalc)
	);

	cpck_parity_gen #(
		.W(CTRL_W)
	) u_rx_chk (
		.data(rx_ctrl_reg),
		.parity(rx_par_recalc)
	);

	// parity line is only looked at while checking is enabled
	assign ext_mismatch = check_en & ~odd_ok(ctrl_from_float, float_to_integer_parity);
	// internal checks never look at the straps
	assign int_rx_mismatch = rx_par_recalc ^ rx_ipar_reg;
	assign int_tx_mismatch = tx_par_recalc ^ tx_par_reg;

	always_comb begin
		cause_next = '0;
		cause_next[cpck_pkg::CPCK_SRC_EXT] = ext_mismatch;
		cause_next[cpck_pkg::CPCK_SRC_INT_RX] = int_rx_mismatch;
		cause_next[cpck_pkg::CPCK_SRC_INT_TX] = int_tx_mismatch;
	end

	assign any_err = |cause_next;

	// outgoing group and its parity line leave from flops together
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tx_ctrl_reg <= '0;
			tx_par_reg <= `CPCK_PAR_RST;
		end else begin
			tx_ctrl_reg <= ctrl_tx;
			tx_par_reg <= tx_par_next;
		end
	end

	// received group held with internally generated parity
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rx_ctrl_reg <= '0;
			rx_ipar_reg <= `CPCK_PAR_RST;
		end else begin
			rx_ctrl_reg <= ctrl_from_float;
			rx_ipar_reg <= rx_ipar_next;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			check_active_reg <= `CPCK_FLAG_RST;
		end else begin
			check_active_reg <= check_en;
		end
	end

	// flag is high for each cycle that follows a detected mismatch
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			flag_reg <= `CPCK_FLAG_RST;
			cause_reg <= '0;
		end else begin
			flag_reg <= any_err;
			cause_reg <= cause_next;
		end
	end

	// set wins over clear so an error in the clearing cycle is kept
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sticky_reg <= `CPCK_FLAG_RST;
		end else begin
			sticky_reg <= any_err | (sticky_reg & ~error_clear);
		end
	end

	assign ctrl_to_float = tx_ctrl_reg;
	assign integer_to_float_parity = tx_par_reg;
	assign ctrl_rx = rx_ctrl_reg;
	assign check_active = check_active_reg;
	assign hardware_error_flag = flag_reg;
	assign error_cause = cause_reg;
	assign error_sticky = sticky_reg;

	property p_ext_flag;
		@(posedge clk) disable iff (!rstn)
		(check_en && !odd_ok(ctrl_from_float, float_to_integer_parity))
			|=> hardware_error_flag;
	endproperty
	a_ext_flag: assert property (p_ext_flag) else $error("received mismatch not flagged");

	property p_ext_cause;
		@(posedge clk) disable iff (!rstn)
		(integer_unit_legacy_strap_n && float_unit_legacy_strap_n
			&& !odd_ok(ctrl_from_float, float_to_integer_parity))
			|=> error_cause[cpck_pkg::CPCK_SRC_EXT];
	endproperty
	a_ext_cause: assert property (p_ext_cause) else $error("enabled check missed error");

	property p_legacy_ignore;
		@(posedge clk) disable iff (!rstn)
		(!integer_unit_legacy_strap_n || !float_unit_legacy_strap_n)
			|=> !error_cause[cpck_pkg::CPCK_SRC_EXT];
	endproperty
	a_legacy_ignore: assert property (p_legacy_ignore) else $error("parity seen in legacy");

	property p_tx_odd;
		@(posedge clk) disable iff (!rstn)
		odd_ok(ctrl_to_float, integer_to_float_parity);
	endproperty
	a_tx_odd: assert property (p_tx_odd) else $error("outgoing parity not odd");

	property p_tx_follow;
		@(posedge clk) disable iff (!rstn)
		1'b1 |=> (ctrl_to_float == $past(ctrl_tx))
			&& (integer_to_float_parity == ~(^$past(ctrl_tx)));
	endproperty
	a_tx_follow: assert property (p_tx_follow) else $error("parity line not with group");

	property p_int_rx;
		@(posedge clk) disable iff (!rstn)
		int_rx_mismatch |=> hardware_error_flag && error_cause[cpck_pkg::CPCK_SRC_INT_RX];
	endproperty
	a_int_rx: assert property (p_int_rx) else $error("internal rx error not flagged");

	property p_int_tx;
		@(posedge clk) disable iff (!rstn)
		int_tx_mismatch |=> hardware_error_flag && error_cause[cpck_pkg::CPCK_SRC_INT_TX];
	endproperty
	a_int_tx: assert property (p_int_tx) else $error("internal tx error not flagged");

	property p_flag_clean;
		@(posedge clk) disable iff (!rstn)
		!any_err |=> !hardware_error_flag && (error_cause == '0);
	endproperty
	a_flag_clean: assert property (p_flag_clean) else $error("flag without a mismatch");

	property p_sticky;
		@(posedge clk) disable iff (!rstn)
		(hardware_error_flag |-> error_sticky)
			and ((error_sticky && !error_clear) |=> error_sticky);
	endproperty
	a_sticky: assert property (p_sticky) else $error("sticky error lost");

	property p_check_active;
		@(posedge clk) disable iff (!rstn)
		1'b1 |=> check_active == $past(check_en);
	endproperty
	a_check_active: assert property (p_check_active) else $error("check state wrong");

endmodule

// >>> verif/cpck_float_model.sv
// float unit stand-in that sends a control group with its parity line
module cpck_float_model (
	input wire logic [7:0] grp,
	input wire logic bad,
	output logic [7:0] data,
	output logic par
);
	timeunit 1ns;
	timeprecision 1ps;
	assign data = grp;
	// bad makes the total even, the only fault the bench asks for
	assign par = ~(^grp) ^ bad;
endmodule

// >>> verif/test_cpck_top.sv
// self-checking bench for the coprocessor control parity checker
module test_cpck_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rstn = 0, s_i_n = 1, s_f_n = 1, clr = 0, bad = 0;
	logic [7:0] tx = 8'h00, grp = 8'h00, fdata, to_flt, rx;
	logic fpar, par_out, act, flag, sticky, en, err, st_exp;
	cpck_pkg::cpck_cause_t cause;
	int bad_count = 0, n_checks = 0, i;
	logic [31:0] seed = 32'h00000022;
	always #2.5 clk = ~clk;
	cpck_float_model fm (.grp(grp), .bad(bad), .data(fdata), .par(fpar));
	cpck_top uut (.clk(clk), .rstn(rstn), .integer_unit_legacy_strap_n(s_i_n),
		.float_unit_legacy_strap_n(s_f_n), .ctrl_tx(tx), .ctrl_to_float(to_flt),
		.integer_to_float_parity(par_out), .ctrl_from_float(fdata),
		.float_to_integer_parity(fpar), .ctrl_rx(rx), .check_active(act),
		.hardware_error_flag(flag), .error_cause(cause), .error_sticky(sticky),
		.error_clear(clr));
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] x;
		x = v ^ (v << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	function automatic logic odd_bit(input logic [7:0] v);
		return ~(^v);
	endfunction
	task automatic cmp(input string nm, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		#20000;
		bad_count++;
		close_out();
	end
	initial begin
		repeat (12) @(posedge clk);
		#1;
		cmp("par_rst", 8'h01, {7'h00, par_out});
		cmp("flag_rst", 8'h00, {4'h0, flag, cause});
		rstn = 1;
		st_exp = 0;
		for (i = 0; i < 600; i++) begin
			seed = xs(seed);
			tx = seed[7:0];
			grp = seed[15:8];
			// opening cases: straps low with bad parity, then back-to-back faults
			bad = (i < 12) ? 1'b1 : (seed[16] & seed[17]);
			s_i_n = (i < 4) ? 1'b0 : ~(seed[20:18] == 3'h0 && seed[21]);
			s_f_n = (i < 8 && i > 1) ? 1'b0 : ~(seed[20:18] == 3'h0 && !seed[21]);
			clr = (i == 13) ? 1'b1 : seed[22];
			en = s_i_n & s_f_n;
			err = bad & en;
			st_exp = err | (st_exp & ~clr);
			@(posedge clk);
			#1;
			cmp("ctrl_to_float", tx, to_flt);
			cmp("tx_parity", {7'h00, odd_bit(tx)}, {7'h00, par_out});
			cmp("ctrl_rx", grp, rx);
			cmp("flag", {7'h00, err}, {7'h00, flag});
			cmp("cause", {7'h00, err}, {5'h00, cause});
			cmp("check_active", {7'h00, en}, {7'h00, act});
			cmp("sticky", {7'h00, st_exp}, {7'h00, sticky});
		end
		$display("test link_parity done");
		close_out();
	end
endmodule
